// File: design/spi_eeprom_command_port.sv
`default_nettype none

// ==========================================================
// write buffer between the command side and the array
module prog_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
    logic full;
    logic empty;

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = store[rd_ptr[PW-1:0]];

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
        end else if (in_valid_i && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_ptr <= '0;
        end else if (out_ready_i && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (in_valid_i && !full) begin
            store[wr_ptr[PW-1:0]] <= in_data_i;
        end
    end
endmodule

// How it works
// - writes to array or lock register need the write latch set beforehand.
// - clear latch opcode drops the write latch; a write already in progress runs to completion.
// - after set latch opcode the rest of that selection is ignored.
// - array write takes 16 address bits, only the low nine are used.
// - at most 16 data bytes per write selection, all in one page.
// - page write address wraps to the page start, overwriting buffered bytes.
// - write commits only if select rises on a byte boundary.
// - select stays low through the whole operation; a rise ends it.
// - lock status read returns lock bits, upper bits zero, when idle.
// - lock status read shows ones while an array write is busy.
// - bit pointer keeps advancing during a busy status poll.
// - array read takes opcode and 16-bit address, low nine bits used.
// - read address increments per byte and wraps from top to zero.
// - sequential read runs until select goes high.
// - config write updates the configuration register at once, volatile.
// - control write updates the control register driving switch and gain outputs.
// - after a control write the next command is accepted at once.
// - status read returns the three status flags.
// - partition lock picks one of seven regions or none; locked bytes are never written.
// - all bytes move most significant bit first.
// - opcodes 06 set, 04 clear, 02 array write, 05 lock status.
// - opcodes 03 read, 09 config, 0a control, 0b status, 01 lock.
// - mode 0: sample on rising clock edge, change output on falling.
// - write latch clears at reset and when a write cycle completes.
module spi_eeprom_command_port
    import spi_cmd_pkg::*;
#(
    parameter int FIFO_DEPTH = PAGE_BYTES
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // serial link pins
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    // device status and control
    input wire logic [2:0] status_flags_i,
    output logic [15:0] config_o,
    output logic [15:0] control_o,
    output logic [2:0] lock_partition_bits_o,
    output logic write_latch_o,
    output logic write_busy_o
);
    // ==========================================================
    // pin synchronisers
    logic cs_s1, cs_s2, cs_s3;
    logic sck_s1, sck_s2, sck_s3;
    logic si_s1, si_s2;
    logic [2:0] stat_s1, stat_s2;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
            stat_s1 <= 3'h0;
            stat_s2 <= 3'h0;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            sck_s1 <= sck_i;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            si_s1 <= si_i;
            si_s2 <= si_s1;
            stat_s1 <= status_flags_i;
            stat_s2 <= stat_s1;
        end
    end

    logic sck_rise, sck_fall, cs_rise;
    assign sck_rise = sck_s2 && !sck_s3 && !cs_s2;
    assign sck_fall = !sck_s2 && sck_s3 && !cs_s2;
    assign cs_rise = cs_s2 && !cs_s3;

    // ==========================================================
    // bit and byte framing
    logic [6:0] shift;
    logic [2:0] bit_cnt;
    logic [7:0] rx_byte;
    logic byte_done;
    assign rx_byte = {shift, si_s2};
    assign byte_done = sck_rise && (bit_cnt == BIT_LAST);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shift <= 7'h00;
            bit_cnt <= 3'h0;
        end else if (cs_s2) begin
            bit_cnt <= 3'h0;
        end else if (sck_rise) begin
            shift <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // ==========================================================
    // command state
    frame_e state;
    opcode_e cmd;
    logic addr_second;
    logic reg_second;
    logic [7:0] reg_hi;
    logic lock_got;
    logic [2:0] lock_pend;
    logic wel;
    prog_e prog;
    logic busy;
    assign busy = (prog != PG_IDLE);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_OPCODE;
            cmd <= OP_CLR_LATCH;
        end else if (cs_s2) begin
            state <= ST_OPCODE;
        end else if (byte_done) begin
            case (state)
                ST_OPCODE: begin
                    cmd <= opcode_e'(rx_byte);
                    case (rx_byte)
                        OP_ARRAY_WR: state <= (wel && !busy) ? ST_ADDR : ST_IGNORE;
                        OP_ARRAY_RD: state <= ST_ADDR;
                        OP_LOCK_STAT: state <= ST_STATOUT;
                        OP_STATUS_RD: state <= ST_STATOUT;
                        OP_CONFIG_WR: state <= ST_REGDATA;
                        OP_CONTROL_WR: state <= ST_REGDATA;
                        OP_PART_LOCK: state <= (wel && !busy) ? ST_REGDATA : ST_IGNORE;
                        default: state <= ST_IGNORE;
                    endcase
                end
                ST_ADDR: begin
                    if (addr_second) begin
                        state <= (cmd == OP_ARRAY_RD) ? ST_RDATA : ST_WDATA;
                    end
                end
                ST_REGDATA: begin
                    if (reg_second && cmd != OP_PART_LOCK) begin
                        state <= ST_IGNORE;
                    end
                end
                default: state <= state;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_second <= 1'b0;
            reg_second <= 1'b0;
        end else if (cs_s2) begin
            addr_second <= 1'b0;
            reg_second <= 1'b0;
        end else if (byte_done) begin
            if (state == ST_ADDR) begin
                addr_second <= !addr_second;
            end
            if (state == ST_REGDATA) begin
                reg_second <= 1'b1;
            end
        end
    end

    // ==========================================================
    // address counter
    logic [ADDR_W-1:0] addr;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr <= '0;
        end else if (byte_done) begin
            if (state == ST_ADDR && !addr_second) begin
                addr[8] <= rx_byte[0];
            end else if (state == ST_ADDR) begin
                addr[7:0] <= rx_byte;
            end else if (state == ST_RDATA) begin
                addr <= addr + 9'h001;
            end else if (state == ST_WDATA) begin
                addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 4'h1;
            end
        end
    end

    // ==========================================================
    // volatile registers and partition lock capture
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_hi <= 8'h00;
            config_o <= CONFIG_RST;
            control_o <= CONTROL_RST;
        end else if (byte_done && state == ST_REGDATA && !reg_second) begin
            reg_hi <= rx_byte;
        end else if (byte_done && state == ST_REGDATA && cmd == OP_CONFIG_WR) begin
            config_o <= {reg_hi, rx_byte};
        end else if (byte_done && state == ST_REGDATA && cmd == OP_CONTROL_WR) begin
            control_o <= {reg_hi, rx_byte};
        end
    end

    // a second lock byte overwrites the first one
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lock_got <= 1'b0;
            lock_pend <= LOCK_RST;
        end else if (cs_s2) begin
            lock_got <= 1'b0;
        end else if (byte_done && state == ST_REGDATA && cmd == OP_PART_LOCK) begin
            lock_got <= 1'b1;
            lock_pend <= rx_byte[2:0];
        end
    end

    // ==========================================================
    // page buffer
    logic [7:0] pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pvalid;
    logic [ADDR_W-PAGE_W-1:0] page;
    logic commit_array, commit_lock;
    logic [PAGE_W-1:0] load_idx;
    logic push, fifo_in_ready;

    assign commit_array = cs_rise && state == ST_WDATA && bit_cnt == 3'h0 && |pvalid && wel;
    assign commit_lock = cs_rise && state == ST_REGDATA && cmd == OP_PART_LOCK
        && bit_cnt == 3'h0 && lock_got && wel;
    assign push = (prog == PG_LOAD) && pvalid[load_idx] && fifo_in_ready;

    generate
        for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_page
            always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    pvalid[i] <= 1'b0;
                    pbuf[i] <= 8'h00;
                end else if (byte_done && state == ST_WDATA && addr[PAGE_W-1:0] == PAGE_W'(i)) begin
                    pvalid[i] <= 1'b1;
                    pbuf[i] <= rx_byte;
                end else if (cs_rise && !commit_array && prog != PG_LOAD) begin
                    pvalid[i] <= 1'b0;
                end else if (push && load_idx == PAGE_W'(i)) begin
                    pvalid[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            page <= '0;
        end else if (commit_array) begin
            page <= addr[ADDR_W-1:PAGE_W];
        end
    end

    // ==========================================================
    // programming engine
    logic [15:0] tmr;
    logic [2:0] lock_reg;
    prog_word_s fifo_out;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic mem_we;
    assign fifo_out_ready = (prog == PG_DRAIN);
    assign mem_we = fifo_out_valid && fifo_out_ready && !locked(lock_reg, fifo_out.addr);

    function automatic logic locked(input logic [2:0] sel, input logic [ADDR_W-1:0] a);
        case (sel)
            3'h1: locked = (a[8:7] == 2'h0);
            3'h2: locked = (a[8:7] == 2'h1);
            3'h3: locked = (a[8:7] == 2'h2);
            3'h4: locked = (a[8:7] == 2'h3);
            3'h5: locked = !a[8];
            3'h6: locked = (a[8:4] == 5'h00);
            3'h7: locked = (a[8:4] == 5'h1f);
            default: locked = 1'b0;
        endcase
    endfunction

    // the loader stalls on the buffer, the drain waits for loading to end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog <= PG_IDLE;
            load_idx <= '0;
            tmr <= 16'h0000;
            lock_reg <= LOCK_RST;
        end else begin
            case (prog)
                PG_IDLE: begin
                    load_idx <= '0;
                    if (commit_array) begin
                        prog <= PG_LOAD;
                    end else if (commit_lock) begin
                        lock_reg <= lock_pend;
                        tmr <= WRITE_CNT;
                        prog <= PG_WAIT;
                    end
                end
                PG_LOAD: begin
                    if (!pvalid[load_idx] || fifo_in_ready) begin
                        load_idx <= load_idx + 4'h1;
                        if (load_idx == 4'hf) begin
                            prog <= PG_DRAIN;
                        end
                    end
                end
                PG_DRAIN: begin
                    if (!fifo_out_valid) begin
                        tmr <= WRITE_CNT;
                        prog <= PG_WAIT;
                    end
                end
                PG_WAIT: begin
                    tmr <= tmr - 16'h0001;
                    if (tmr == 16'h0001) begin
                        prog <= PG_IDLE;
                    end
                end
                default: prog <= PG_IDLE;
            endcase
        end
    end

    prog_fifo #(
        .WIDTH($bits(prog_word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i((prog == PG_LOAD) && pvalid[load_idx]),
        .in_ready_o(fifo_in_ready),
        .in_data_i({page, load_idx, pbuf[load_idx]}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out)
    );

    // array storage has no reset; its contents stand for nonvolatile data
    logic [7:0] mem [ARRAY_BYTES];
    always_ff @(posedge clk_sys_i) begin
        if (mem_we) begin
            mem[fifo_out.addr] <= fifo_out.data;
        end
    end

    // ==========================================================
    // write latch: a set in the same cycle as a completion wins
    logic prog_done;
    assign prog_done = (prog == PG_WAIT) && (tmr == 16'h0001);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wel <= 1'b0;
        end else if (byte_done && state == ST_OPCODE && rx_byte == OP_SET_LATCH) begin
            wel <= 1'b1;
        end else if (byte_done && state == ST_OPCODE && rx_byte == OP_CLR_LATCH) begin
            wel <= 1'b0;
        end else if (prog_done) begin
            wel <= 1'b0;
        end
    end

    // ==========================================================
    // serial output, changed on falling clock edges
    logic [7:0] tx_byte;
    always_comb begin
        tx_byte = mem[addr];
        if (state == ST_STATOUT && cmd == OP_STATUS_RD) begin
            tx_byte = {5'h00, stat_s2};
        end else if (state == ST_STATOUT) begin
            tx_byte = busy ? 8'hff : {5'h00, lock_reg};
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            so_oe_o <= !cs_s2;
            if (cs_s2) begin
                so_o <= 1'b0;
            end else if (sck_fall && (state == ST_RDATA || state == ST_STATOUT)) begin
                so_o <= tx_byte[BIT_LAST - bit_cnt];
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            write_latch_o <= 1'b0;
            write_busy_o <= 1'b0;
            lock_partition_bits_o <= LOCK_RST;
        end else begin
            write_latch_o <= wel;
            write_busy_o <= busy;
            lock_partition_bits_o <= lock_reg;
        end
    end

    // ==========================================================
    // checks
    a_commit_needs_latch: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(busy) |-> $past(wel))
        else $error("write started without the write latch");
    a_clear_latch: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (byte_done && state == ST_OPCODE && rx_byte == OP_CLR_LATCH) |=> ##1 !write_latch_o)
        else $error("clear opcode left the latch set");
    a_ignore_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == ST_IGNORE && !cs_s2) |=> (state == ST_IGNORE || cs_s2))
        else $error("ignored frame resumed before deselect");
    a_page_wrap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (byte_done && state == ST_WDATA && addr[3:0] == 4'hf) |=> addr[3:0] == 4'h0 && $stable(addr[8:4]))
        else $error("page address did not wrap");
    a_busy_high: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (sck_fall && state == ST_STATOUT && cmd == OP_LOCK_STAT && busy) |=> so_o)
        else $error("busy poll did not show a high output");
    a_lock_upper_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (sck_fall && state == ST_STATOUT && cmd == OP_LOCK_STAT && !busy && bit_cnt < 3'h5) |=> !so_o)
        else $error("reserved lock status bit not zero");
    a_read_wrap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (byte_done && state == ST_RDATA && addr == 9'h1ff) |=> addr == 9'h000)
        else $error("read address did not wrap to zero");
    a_locked_untouched: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        mem_we |-> !((lock_reg == 3'h1 && fifo_out.addr < 9'h080) || (lock_reg == 3'h5 && fifo_out.addr < 9'h100)
            || (lock_reg == 3'h2 && fifo_out.addr >= 9'h080 && fifo_out.addr < 9'h100)
            || (lock_reg == 3'h3 && fifo_out.addr >= 9'h100 && fifo_out.addr < 9'h180)
            || (lock_reg == 3'h4 && fifo_out.addr >= 9'h180) || (lock_reg == 3'h6 && fifo_out.addr < 9'h010)
            || (lock_reg == 3'h7 && fifo_out.addr >= 9'h1f0)))
        else $error("locked byte written");
    a_latch_autoclear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (prog_done && !(byte_done && state == ST_OPCODE && rx_byte == OP_SET_LATCH)) |=> ##1 !write_latch_o)
        else $error("latch not cleared after write cycle");
    a_config_apply: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (byte_done && state == ST_REGDATA && reg_second && cmd == OP_CONFIG_WR)
        |=> config_o == {$past(reg_hi), $past(rx_byte)})
        else $error("configuration not updated");
endmodule
`default_nettype wire

// File: pkg/spi_cmd_pkg.sv
`default_nettype none
package spi_cmd_pkg;

    // ==========================================================
    // command opcodes, shifted in msb first
    typedef enum logic [7:0] {
        OP_SET_LATCH  = 8'h06,
        OP_CLR_LATCH  = 8'h04,
        OP_ARRAY_WR   = 8'h02,
        OP_LOCK_STAT  = 8'h05,
        OP_ARRAY_RD   = 8'h03,
        OP_CONFIG_WR  = 8'h09,
        OP_CONTROL_WR = 8'h0a,
        OP_STATUS_RD  = 8'h0b,
        OP_PART_LOCK  = 8'h01
    } opcode_e;

    // ==========================================================
    // frame and programming states
    typedef enum logic [2:0] {
        ST_OPCODE  = 3'b000,
        ST_ADDR    = 3'b001,
        ST_WDATA   = 3'b010,
        ST_RDATA   = 3'b011,
        ST_REGDATA = 3'b100,
        ST_STATOUT = 3'b101,
        ST_IGNORE  = 3'b110
    } frame_e;

    typedef enum logic [1:0] {
        PG_IDLE  = 2'b00,
        PG_LOAD  = 2'b01,
        PG_DRAIN = 2'b10,
        PG_WAIT  = 2'b11
    } prog_e;

    // ==========================================================
    // geometry, reset values and timing
    localparam int ADDR_W = 9;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam int ARRAY_BYTES = 512;
    localparam logic [15:0] CONFIG_RST = 16'h0000;
    localparam logic [15:0] CONTROL_RST = 16'h0000;
    localparam logic [2:0] LOCK_RST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_US = 5;
    localparam int WRITE_CYCLES = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] WRITE_CNT = 16'(WRITE_CYCLES);

    // one byte bound for the array, carried through the write buffer
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } prog_word_s;

endpackage
`default_nettype wire

// File: sim/spi_host_model.sv
`default_nettype none
// ==========================================================
// serial bus master, mode 0, one byte per call
module spi_host_model (
    // clock
    input wire logic clk_sys_i,
    // link pins
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    task automatic frame_start();
        @(negedge clk_sys_i);
        cs_n_o = 1'b0;
        repeat (4) @(negedge clk_sys_i);
    endtask
    // si changes only while sck is low; 16 clk per bit gives a 160 ns link clock
    // fewer than eight bits cuts the byte short, for cancelled writes
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int nbits);
        for (int i = 7; i > 7 - nbits; i--) begin
            si_o = tx[i];
            repeat (8) @(negedge clk_sys_i);
            sck_o = 1'b1;
            rx[i] = so_i;
            repeat (8) @(negedge clk_sys_i);
            sck_o = 1'b0;
        end
        // the line carries no held value once the byte is over
        si_o = ~si_o;
    endtask
    // select rises four clocks after the last bit sent, whether or not that byte was whole
    task automatic frame_end();
        repeat (4) @(negedge clk_sys_i);
        cs_n_o = 1'b1;
        repeat (6) @(negedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// File: sim/tb_spi_eeprom_command_port.sv
`default_nettype none
module tb_spi_eeprom_command_port
    import spi_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, sys_rst_i, sck, cs_n, si, so, so_oe, latch, busy;
    logic [2:0] flags, lock;
    logic [15:0] cfg_w, ctl_w;
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    int error_cnt = 0;
    int tests_run = 0;
    int last_bits = 8;
    typedef struct packed {
        logic [7:0] op;
        logic [15:0] val;
        logic [15:0] cfg;
        logic [15:0] ctl;
    } row_s;
    row_s rows[4] = '{
        '{8'h09, 16'h12a5, 16'h12a5, 16'h0000},
        '{8'h0a, 16'h5a3c, 16'h12a5, 16'h5a3c},
        '{8'hff, 16'hffff, 16'h12a5, 16'h5a3c},
        '{8'h09, 16'hc001, 16'hc001, 16'h5a3c}};
    spi_eeprom_command_port u_spi_eeprom_command_port (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .so_o(so), .so_oe_o(so_oe), .status_flags_i(flags), .config_o(cfg_w), .control_o(ctl_w),
        .lock_partition_bits_o(lock), .write_latch_o(latch), .write_busy_o(busy));
    spi_host_model u_spi_host_model (
        .clk_sys_i(clk_sys_i), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic run_frame();
        logic [7:0] r;
        rx_q = {};
        u_spi_host_model.frame_start();
        check(so_oe, 1'b1);
        foreach (tx_q[i]) begin
            u_spi_host_model.xfer(tx_q[i], r, (i == tx_q.size() - 1) ? last_bits : 8);
            rx_q.push_back(r);
        end
        u_spi_host_model.frame_end();
    endtask
    // latch in a frame of its own, then the queued frame
    task automatic nv_frame();
        logic [7:0] keep[$];
        keep = tx_q;
        tx_q = {OP_SET_LATCH};
        run_frame();
        tx_q = keep;
        run_frame();
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n >= 2000) begin
            error_cnt++;
            test_done();
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        sys_rst_i = 1'b1;
        flags = 3'b101;
        repeat (2) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        check({latch, busy, so_oe, lock, cfg_w | ctl_w}, 24'h0);
        foreach (rows[i]) begin
            tx_q = {rows[i].op, rows[i].val[15:8], rows[i].val[7:0]};
            run_frame();
            check(cfg_w, rows[i].cfg);
            check(ctl_w, rows[i].ctl);
        end
        tx_q = {OP_STATUS_RD, 8'h00};
        run_frame();
        check(rx_q[1], 8'h05);
        tx_q = {OP_ARRAY_WR, 8'h00, 8'h10, 8'haa};
        run_frame();
        check({latch, busy}, 0);
        tx_q = {OP_SET_LATCH, OP_ARRAY_WR, 8'h00, 8'h10, 8'haa};
        run_frame();
        check({latch, busy}, 2'b10);
        // select rises mid-byte: the write is dropped and the latch stays set
        last_bits = 4;
        tx_q = {OP_ARRAY_WR, 8'h00, 8'h20, 8'h55};
        run_frame();
        last_bits = 8;
        check({latch, busy}, 2'b10);
        tx_q = {OP_CLR_LATCH};
        run_frame();
        check(latch, 0);
        // three bytes from 1fe wrap inside the page onto 1f0
        tx_q = {OP_ARRAY_WR, 8'h01, 8'hfe, 8'h11, 8'h22, 8'h33};
        nv_frame();
        tx_q = {OP_LOCK_STAT, 8'h00, 8'h00};
        run_frame();
        check({rx_q[1], rx_q[2]}, 16'hffff);
        wait_idle();
        check(latch, 0);
        tx_q = {OP_ARRAY_WR, 8'h00, 8'h00, 8'h44};
        nv_frame();
        wait_idle();
        tx_q = {OP_ARRAY_RD, 8'h01, 8'hfe, 8'h00, 8'h00, 8'h00};
        run_frame();
        check({rx_q[3], rx_q[4]}, 16'h1122);
        check(rx_q[5], 8'h44);
        tx_q = {OP_ARRAY_RD, 8'h01, 8'hf0, 8'h00};
        run_frame();
        check(rx_q[3], 8'h33);
        tx_q = {OP_PART_LOCK, 8'h07};
        nv_frame();
        wait_idle();
        check(lock, 3'h7);
        tx_q = {OP_LOCK_STAT, 8'h00};
        run_frame();
        check(rx_q[1], 8'h07);
        tx_q = {OP_ARRAY_WR, 8'h01, 8'hff, 8'h99};
        nv_frame();
        wait_idle();
        tx_q = {OP_ARRAY_RD, 8'h01, 8'hff, 8'h00};
        run_frame();
        check(rx_q[3], 8'h22);
        // reset in mid-run brings every output back to its idle value
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        check({latch, busy, so_oe, lock, cfg_w | ctl_w}, 24'h0);
        test_done();
    end
endmodule
`default_nettype wire
